// >>> design/pwc_top.sv
// Purpose: periodic wakeup counter with wishbone register access
// Assumes: classic wishbone, one ack per request, 8-bit data in lane 0
// Notes: clk_en low freezes every flip-flop of the block
`timescale 1ns/1ps
`include "pwc_cfg.svh"
module pwc_top
    import pwc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic low_power_osc_clock,
    input wire logic external_ref_clock,
    input wire logic internal_ref_clock,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o
);
    pwc_wb_req_type req;
    pwc_bus_state_type bus_q;
    pwc_bus_state_type bus_d;
    pwc_ctrl_type ctrl_q;
    pwc_ctrl_type ctrl_d;
    pwc_ctrl_type wr_ctrl;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] mod_q;
    logic [7:0] mod_d;
    logic flag_q;
    logic flag_d;
    logic irq_q;
    logic irq_d;
    logic access;
    logic commit;
    logic wr_sc;
    logic wr_mod;
    logic wr_cnt;
    logic clr;
    logic flag_set;
    logic src_rise;
    logic tick;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr == ofs);
    endfunction

    function automatic logic [31:0] sc_word(input pwc_ctrl_type c, input logic f);
        sc_word = `PWC_RD_ZERO;
        sc_word[`PWC_FLAG_BIT] = f;
        sc_word[`PWC_CS_HI:`PWC_CS_LO] = c.clock_select;
        sc_word[`PWC_IE_BIT] = c.interrupt_enable;
        sc_word[`PWC_PS_HI:`PWC_PS_LO] = c.prescaler_select;
    endfunction

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
        sel: wb_sel_i, dat: wb_dat_i};

    // bus answer: ack one cycle after the request; writes act on the ack edge
    assign access = req.cyc && req.stb;
    assign commit = access && (bus_q == PWC_ACK) && req.we && req.sel[0];
    assign wr_sc = commit && hit(req.adr, `PWC_SC_OFS);
    assign wr_mod = commit && hit(req.adr, `PWC_MOD_OFS);
    assign wr_cnt = commit && hit(req.adr, `PWC_CNT_OFS);

    always_comb
    begin
        wr_ctrl.clock_select = req.dat[`PWC_CS_HI:`PWC_CS_LO];
        wr_ctrl.interrupt_enable = req.dat[`PWC_IE_BIT];
        wr_ctrl.prescaler_select = req.dat[`PWC_PS_HI:`PWC_PS_LO];
    end

    always_comb
    begin
        bus_d = PWC_IDLE;
        rdat_d = rdat_q;
        case (bus_q)
            PWC_IDLE:
            begin
                if (access)
                begin
                    bus_d = PWC_ACK;
                    if (hit(req.adr, `PWC_SC_OFS))
                        rdat_d = sc_word(ctrl_q, flag_q);
                    else if (hit(req.adr, `PWC_CNT_OFS))
                        rdat_d = {24'h000000, count_q};
                    else if (hit(req.adr, `PWC_MOD_OFS))
                        rdat_d = {24'h000000, mod_q};
                    else
                        rdat_d = `PWC_RD_ZERO; // unmapped reads zero, still acked
                end
            end
            PWC_ACK: bus_d = PWC_IDLE;
            default: bus_d = PWC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_q <= PWC_IDLE;
            rdat_q <= `PWC_RD_ZERO;
        end
        else if (clk_en)
        begin
            bus_q <= bus_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = (bus_q == PWC_ACK);
    assign wb_dat_o = rdat_q;

    // a change of either select restarts timing from zero
    assign clr = wr_mod
        || (wr_sc && (wr_ctrl.clock_select != ctrl_q.clock_select))
        || (wr_sc && (wr_ctrl.prescaler_select != ctrl_q.prescaler_select));

    pwc_src_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .low_power_osc_clock(low_power_osc_clock),
        .external_ref_clock(external_ref_clock),
        .internal_ref_clock(internal_ref_clock),
        .clock_select(ctrl_q.clock_select),
        .src_rise(src_rise)
    );

    pwc_prescaler u_presc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .clear(clr),
        .prescaler_select(ctrl_q.prescaler_select),
        .cs_lsb(ctrl_q.clock_select[0]),
        .src_rise(src_rise),
        .tick(tick)
    );

    // counter, flag and registers; a clear in the same cycle beats a tick
    always_comb
    begin
        ctrl_d = ctrl_q;
        mod_d = mod_q;
        count_d = count_q;
        flag_set = 1'b0;
        if (wr_sc)
            ctrl_d = wr_ctrl;
        if (wr_mod)
            mod_d = req.dat[7:0];
        if (clr)
            count_d = `PWC_CNT_RST;
        else if (tick)
        begin
            if (count_q == mod_q)
            begin
                count_d = `PWC_CNT_RST;
                flag_set = 1'b1;
            end
            else
                count_d = count_q + 8'h01;
        end
        flag_d = flag_q;
        if (wr_sc && req.dat[`PWC_FLAG_BIT])
            flag_d = 1'b0;
        if (flag_set)
            flag_d = 1'b1; // set wins over a same-cycle clear
        irq_d = flag_d && ctrl_d.interrupt_enable;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q.clock_select <= `PWC_CS_LPO;
            ctrl_q.interrupt_enable <= 1'b0;
            ctrl_q.prescaler_select <= `PWC_PS_OFF;
            mod_q <= `PWC_MOD_RST;
            count_q <= `PWC_CNT_RST;
            flag_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (clk_en)
        begin
            ctrl_q <= ctrl_d;
            mod_q <= mod_d;
            count_q <= count_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
        end
    end

    assign irq_o = irq_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    presc_off_idle_a: assert property (
        ctrl_q.prescaler_select == `PWC_PS_OFF |-> !tick && count_q == `PWC_CNT_RST
            || $past(count_q) == count_q)
        else $error("count moved with the prescaler off");

    cs_change_clr_a: assert property (
        clk_en && wr_sc && wr_ctrl.clock_select != ctrl_q.clock_select
            |=> count_q == `PWC_CNT_RST && ctrl_q.clock_select == $past(wr_ctrl.clock_select))
        else $error("clock select change did not clear count");

    ps_change_clr_a: assert property (
        clk_en && wr_sc && wr_ctrl.prescaler_select != ctrl_q.prescaler_select
            |=> count_q == `PWC_CNT_RST)
        else $error("prescaler select change did not clear count");

    mod_write_clr_a: assert property (
        clk_en && wr_mod |=> count_q == `PWC_CNT_RST && mod_q == $past(req.dat[7:0]))
        else $error("modulo write did not clear count");

    count_step_a: assert property (
        clk_en && tick && !clr && count_q != mod_q
            |=> count_q == $past(count_q) + 8'h01 && !$rose(flag_q))
        else $error("count did not step by one");

    match_wrap_a: assert property (
        clk_en && tick && !clr && count_q == mod_q |=> count_q == `PWC_CNT_RST && flag_q)
        else $error("match did not wrap and set flag");

    irq_follows_a: assert property (
        irq_o == (flag_q && ctrl_q.interrupt_enable))
        else $error("interrupt request differs from flag and enable");

    flag_clear_a: assert property (
        clk_en && wr_sc && req.dat[`PWC_FLAG_BIT] && !flag_set |=> !flag_q ##0 !irq_o)
        else $error("writing one did not clear the flag");

    flag_keep_a: assert property (
        clk_en && wr_sc && !req.dat[`PWC_FLAG_BIT] && flag_q |=> flag_q)
        else $error("writing zero changed the flag");

    count_ro_a: assert property (
        clk_en && wr_cnt && !tick && !clr |=> $stable(count_q))
        else $error("count register write changed the count");

    ack_pulse_a: assert property (
        wb_ack_o && clk_en |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
endmodule

// >>> include/pwc_cfg.svh
// Purpose: constants for the periodic wakeup counter
// Assumes: included by bare name by every design file
// Notes: offsets are byte addresses on a 32-bit wishbone bus
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH
`define PWC_SC_OFS 8'h00
`define PWC_CNT_OFS 8'h04
`define PWC_MOD_OFS 8'h08
`define PWC_FLAG_BIT 7
`define PWC_CS_HI 6
`define PWC_CS_LO 5
`define PWC_IE_BIT 4
`define PWC_PS_HI 3
`define PWC_PS_LO 0
`define PWC_CNT_RST 8'h00
`define PWC_MOD_RST 8'h00
`define PWC_CS_LPO 2'h0
`define PWC_CS_EXT 2'h1
`define PWC_PS_OFF 4'h0
`define PWC_DIV_ZERO 18'h00000
`define PWC_DIV_ONE 18'h00001
`define PWC_RD_ZERO 32'h00000000
`endif

// >>> include/pwc_pkg.sv
// Purpose: shared types of the periodic wakeup counter
// Assumes: nothing beyond the cfg header
// Notes: control fields travel as one struct
package pwc_pkg;
    typedef struct packed {
        logic [1:0] clock_select;
        logic interrupt_enable;
        logic [3:0] prescaler_select;
    } pwc_ctrl_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pwc_wb_req_type;

    typedef enum logic {PWC_IDLE, PWC_ACK} pwc_bus_state_type;
endpackage

// >>> design/pwc_src_sync.sv
// Purpose: select counter clock source and bring its rising edge into ref_clk
// Assumes: source clocks are slower than half of ref_clk
// Notes: a glitch at a source switch reaches src_rise two cycles after the switch clears counts, so it can be counted
`timescale 1ns/1ps
`include "pwc_cfg.svh"
module pwc_src_sync
    import pwc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic low_power_osc_clock,
    input wire logic external_ref_clock,
    input wire logic internal_ref_clock,
    input wire logic [1:0] clock_select,
    output logic src_rise
);
    logic sel_src;
    logic meta_q;
    logic stab_q;
    logic last_q;

    always_comb
    begin
        case (clock_select)
            `PWC_CS_LPO: sel_src = low_power_osc_clock;
            `PWC_CS_EXT: sel_src = external_ref_clock;
            default: sel_src = internal_ref_clock;
        endcase
    end

    // edge taken from second and third stages only
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            stab_q <= 1'b0;
            last_q <= 1'b0;
        end
        else if (clk_en)
        begin
            meta_q <= sel_src;
            stab_q <= meta_q;
            last_q <= stab_q;
        end
    end

    assign src_rise = stab_q & ~last_q;
endmodule

// >>> design/pwc_prescaler.sv
// Purpose: binary or decimal prescaler of the selected source edges
// Assumes: src_rise is a one-cycle pulse per source period
// Notes: tick is combinational, one cycle, at the last edge of a period
`timescale 1ns/1ps
`include "pwc_cfg.svh"
module pwc_prescaler
    import pwc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic [3:0] prescaler_select,
    input wire logic cs_lsb,
    input wire logic src_rise,
    output logic tick
);
    logic [17:0] cnt_q;
    logic [17:0] cnt_d;
    logic [17:0] ratio;

    function automatic logic [17:0] div_ratio(input logic lsb, input logic [3:0] ps);
        logic [4:0] key;
        key = {lsb, ps};
        case (key)
            5'h01: div_ratio = 18'h00008;
            5'h02: div_ratio = 18'h00020;
            5'h03: div_ratio = 18'h00040;
            5'h04: div_ratio = 18'h00080;
            5'h05: div_ratio = 18'h00100;
            5'h06: div_ratio = 18'h00200;
            5'h07: div_ratio = 18'h00400;
            5'h08: div_ratio = 18'h00001;
            5'h09: div_ratio = 18'h00002;
            5'h0A: div_ratio = 18'h00004;
            5'h0B: div_ratio = 18'h0000A;
            5'h0C: div_ratio = 18'h00010;
            5'h0D: div_ratio = 18'h00064;
            5'h0E: div_ratio = 18'h001F4;
            5'h0F: div_ratio = 18'h003E8;
            5'h11: div_ratio = 18'h00400;
            5'h12: div_ratio = 18'h00800;
            5'h13: div_ratio = 18'h01000;
            5'h14: div_ratio = 18'h02000;
            5'h15: div_ratio = 18'h04000;
            5'h16: div_ratio = 18'h08000;
            5'h17: div_ratio = 18'h10000;
            5'h18: div_ratio = 18'h003E8;
            5'h19: div_ratio = 18'h007D0;
            5'h1A: div_ratio = 18'h01388;
            5'h1B: div_ratio = 18'h02710;
            5'h1C: div_ratio = 18'h04E20;
            5'h1D: div_ratio = 18'h0C350;
            5'h1E: div_ratio = 18'h186A0;
            5'h1F: div_ratio = 18'h30D40;
            default: div_ratio = `PWC_DIV_ZERO;
        endcase
    endfunction

    assign ratio = div_ratio(cs_lsb, prescaler_select);
    assign tick = (prescaler_select != `PWC_PS_OFF) && src_rise
        && (cnt_q == ratio - `PWC_DIV_ONE);

    always_comb
    begin
        cnt_d = cnt_q;
        if (clear || prescaler_select == `PWC_PS_OFF)
            cnt_d = `PWC_DIV_ZERO;
        else if (tick)
            cnt_d = `PWC_DIV_ZERO;
        else if (src_rise)
            cnt_d = cnt_q + `PWC_DIV_ONE;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= `PWC_DIV_ZERO;
        else if (clk_en)
            cnt_q <= cnt_d;
    end

    tick_on_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick |-> src_rise && prescaler_select != `PWC_PS_OFF)
        else $error("prescaler tick without a source edge");
endmodule

// >>> verif/periodic_wakeup_counter_tb.sv
// Purpose: self-checking bench of the periodic wakeup counter
// Assumes: the bench drives the three source pins itself, idle low
// Notes: source pulses are counted by the bench, so counts are exact
`timescale 1ns/1ps
`include "pwc_cfg.svh"
module periodic_wakeup_counter_tb
    import pwc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] src = 3'h0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_i = 32'h00000000;
    logic [3:0] sel = 4'h0;
    logic hi;
    logic [31:0] dat_o;
    logic ack;
    logic irq;
    logic [7:0] rd;
    logic [7:0] m;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int seed_draw;
    int r;
    int exp_cnt;
    // source edges per prescaler period, clock select bit 0 low / high
    int rat0[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
    int rat1[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536,
                     1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};

    pwc_top u_pwc_top (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .low_power_osc_clock(src[0]),
        .external_ref_clock(src[1]),
        .internal_ref_clock(src[2]),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(dat_i),
        .wb_dat_o(dat_o),
        .wb_ack_o(ack),
        .irq_o(irq)
    );

    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ceiling well above the roughly 32k cycles the sequence needs
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            fail_count++;
            stop_test;
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // classic single cycle; ack and read data sampled at the same edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        sel <= 4'hF;
        we <= w;
        adr <= a;
        dat_i <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = dat_o[7:0];
        hi = |dat_o[31:8];
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        if (ack !== 1'b1)
            chk("bus ack", 8'h01, 8'h00);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
        xfer(1'b0, a, 8'h00);
        chk(nm, e, rd);
        chk({nm, " upper bits"}, 8'h00, {7'h00, hi});
    endtask

    task automatic sc(input logic [1:0] c, input logic ie, input logic [3:0] p, input logic f);
        xfer(1'b1, `PWC_SC_OFS, {f, c, ie, p});
    endtask

    // four ref_clk cycles per source period, then room for the synchroniser
    task automatic pulse(input int s, input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            src[s] <= 1'b1;
            repeat (2) @(posedge ref_clk);
            src[s] <= 1'b0;
            @(posedge ref_clk);
        end
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic reset_chk;
        rd_chk(`PWC_SC_OFS, 8'h00, "control");
        rd_chk(`PWC_CNT_OFS, 8'h00, "count");
        rd_chk(`PWC_MOD_OFS, 8'h00, "modulo");
        chk("irq", 8'h00, {7'h00, irq});
    endtask

    initial
    begin
        seed_draw = $urandom(32'hD4FB0322);
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        reset_chk;
        pulse(0, 20);
        rd_chk(`PWC_CNT_OFS, 8'h00, "count");
        xfer(1'b1, `PWC_MOD_OFS, 8'hFF);
        for (int c = 0; c < 2; c++)
            for (int p = 1; p < 16; p++)
            begin
                // long ratios of the high range are sampled at two codes only
                if (c == 1 && p != 1 && p != 8)
                    continue;
                sc(c[1:0], 1'b0, p[3:0], 1'b0);
                r = (c == 1) ? rat1[p] : rat0[p];
                pulse(c, r - 1);
                rd_chk(`PWC_CNT_OFS, 8'h00, "count");
                pulse(c, 1);
                rd_chk(`PWC_CNT_OFS, 8'h01, "count");
            end
        sc(2'h3, 1'b0, 4'h8, 1'b0);
        rd_chk(`PWC_CNT_OFS, 8'h00, "count");
        for (int c = 0; c < 4; c++)
        begin
            sc(c[1:0], 1'b0, 4'h8, 1'b0);
            exp_cnt = 0;
            // odd selects also set the ratio bit, so code 8 needs a long burst
            for (int s = 0; s < 3; s++)
            begin
                if (s == ((c > 1) ? 2 : c))
                begin
                    pulse(s, c[0] ? rat1[8] : 2);
                    exp_cnt += c[0] ? 1 : 2;
                end
                else
                    pulse(s, 2);
                rd_chk(`PWC_CNT_OFS, exp_cnt[7:0], "count");
            end
        end
        sc(2'h0, 1'b0, 4'h0, 1'b0);
        pulse(0, 5);
        rd_chk(`PWC_CNT_OFS, 8'h00, "count");
        m = 8'($urandom_range(6, 2));
        sc(2'h0, 1'b1, 4'h8, 1'b0);
        pulse(0, 3);
        xfer(1'b1, `PWC_MOD_OFS, m);
        rd_chk(`PWC_CNT_OFS, 8'h00, "count");
        pulse(0, m);
        rd_chk(`PWC_CNT_OFS, m, "count");
        xfer(1'b1, `PWC_CNT_OFS, 8'hA5);
        rd_chk(`PWC_CNT_OFS, m, "count");
        rd_chk(`PWC_SC_OFS, 8'h18, "control");
        chk("irq", 8'h00, {7'h00, irq});
        pulse(0, 1);
        rd_chk(`PWC_CNT_OFS, 8'h00, "count");
        rd_chk(`PWC_SC_OFS, 8'h98, "control");
        chk("irq", 8'h01, {7'h00, irq});
        sc(2'h0, 1'b1, 4'h8, 1'b0);
        rd_chk(`PWC_SC_OFS, 8'h98, "control");
        sc(2'h0, 1'b1, 4'h8, 1'b1);
        rd_chk(`PWC_SC_OFS, 8'h18, "control");
        chk("irq", 8'h00, {7'h00, irq});
        xfer(1'b1, `PWC_MOD_OFS, 8'h00);
        sc(2'h0, 1'b0, 4'h8, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            pulse(0, 1);
            rd_chk(`PWC_SC_OFS, 8'h88, "control");
            chk("irq", 8'h00, {7'h00, irq});
            sc(2'h0, 1'b0, 4'h8, 1'b1);
            rd_chk(`PWC_SC_OFS, 8'h08, "control");
        end
        for (int i = 0; i < 4; i++)
        begin
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom_range(255, 0));
            xfer(1'b1, `PWC_MOD_OFS, m);
            rd_chk(`PWC_MOD_OFS, m, "modulo");
        end
        // frozen block must miss source edges; flag checked below stays clear
        @(posedge ref_clk);
        clk_en <= 1'b0;
        pulse(0, 3);
        clk_en <= 1'b1;
        rd_chk(`PWC_CNT_OFS, 8'h00, "count");
        // unmapped place: acked, reads zero, write lost
        xfer(1'b1, 8'h0C, 8'h7F);
        rd_chk(8'h0C, 8'h00, "unmapped");
        rd_chk(`PWC_SC_OFS, 8'h08, "control");
        sc(2'h2, 1'b1, 4'h5, 1'b0);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        reset_chk;
        stop_test;
    end
endmodule
